// >>> inc/module_disable_pkg.sv
// package: register map, field layout and reset values of the disable bank
package module_disable_pkg;
   // register layout
   localparam int          REG_WIDTH          = 16;
   localparam logic [11:0] DISABLE_CTRL7_OFFS = 12'h000;
   localparam int          DMA_DIS_BIT        = 4;
   localparam int          TRIG_DIS_BIT       = 3;
   localparam logic [15:0] DISABLE_CTRL7_RST  = 16'h0000;
   localparam logic [15:0] DISABLE_CTRL7_MASK = 16'h0018;
   // apply delay: one instruction cycle, counted in pclk cycles
   localparam int          APPLY_DELAY_CYC    = 1;
   localparam int          DMA_CHANNELS       = 4;

   // module-disable outputs that travel together
   typedef struct packed
   {
      logic dma_dis;
      logic trig_dis;
   } disable_bus_t;
endpackage

// >>> src/disable_apply.sv
// delay stage that applies a new disable state one cycle after it is written
`timescale 1ns/100ps
module disable_apply
   import module_disable_pkg::*;
(
   // clock and reset
   input  wire logic         pclk,
   input  wire logic         presetn,
   // disable state in and applied out
   input  wire disable_bus_t state_in,
   output disable_bus_t      state_out
);
   disable_bus_t apply_reg;
   disable_bus_t apply_next;

   // follow the stored bits; reset leaves both modules enabled
   always_comb
   begin
      apply_next = state_in; // RULE_06
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         apply_reg <= '0; // RULE_08
      else
         apply_reg <= apply_next;
   end

   assign state_out = apply_reg;
endmodule

// >>> src/module_disable_bank.sv
// apb slave holding disable control register 7 for dma and trigger generator
//
// Our own choices: the register offsets and register access over APB.
`timescale 1ns/100ps
// Function
// RULE_01: writing one to bit 4 holds the dma controller disabled.
// RULE_02: bit 4 cleared lets the dma controller run.
// RULE_03: one dma disable bit gates all four channels together.
// RULE_04: bit 3 disables the trigger generator when one.
// RULE_05: bits 15:5 and 2:0 read zero, writes ignored.
// RULE_06: new disable state is applied one cycle after the write.
// RULE_07: a module runs only if its bit is clear and it is present.
// RULE_08: reset clears both disable bits, modules start enabled.
module module_disable_bank
   import module_disable_pkg::*;
#(
   parameter int          CHANNELS    = DMA_CHANNELS,
   parameter bit          DMA_PRESENT = 1'b1,
   parameter bit          TRIG_PRESENT = 1'b1
)
(
   // apb clock and reset
   input  wire logic                pclk,
   input  wire logic                presetn,
   // apb slave
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [11:0]         paddr,
   input  wire logic [31:0]         pwdata,
   output logic      [31:0]         prdata,
   output logic                     pready,
   output logic                     pslverr,
   // module-disable outputs
   output logic      [CHANNELS-1:0] dma_channel_disable,
   output logic                     trigger_generator_disable
);
   logic [15:0]   ctrl_reg;
   logic [15:0]   ctrl_next;
   logic [31:0]   prdata_reg;
   logic [31:0]   prdata_next;
   logic          pslverr_reg;
   logic          pslverr_next;
   logic [CHANNELS-1:0] dma_out_reg;
   logic [CHANNELS-1:0] dma_out_next;
   logic          trig_out_reg;
   logic          trig_out_next;
   disable_bus_t  stored;
   disable_bus_t  applied;
   logic          setup;
   logic          hit;

   // word-aligned decode of the single register
   function automatic logic addr_hit(input logic [11:0] a);
      addr_hit = (a[11:2] == DISABLE_CTRL7_OFFS[11:2]);
   endfunction

   // zero-wait slave: setup cycle captures, access completes at once
   assign setup = psel & ~penable;
   assign hit   = addr_hit(paddr);

   // register write and read data; unimplemented bits masked off
   always_comb
   begin
      ctrl_next    = ctrl_reg;
      prdata_next  = prdata_reg;
      pslverr_next = 1'b0;
      if (setup)
      begin
         if (!hit)
         begin
            pslverr_next = 1'b1; // unmapped: error, reads zero
            prdata_next  = 32'h0000_0000;
         end
         else if (pwrite)
            ctrl_next = pwdata[15:0] & DISABLE_CTRL7_MASK; // RULE_05
         else
            prdata_next = {16'h0000, ctrl_reg & DISABLE_CTRL7_MASK}; // RULE_05
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_reg    <= DISABLE_CTRL7_RST; // RULE_08
         prdata_reg  <= 32'h0000_0000;
         pslverr_reg <= 1'b0;
      end
      else
      begin
         ctrl_reg    <= ctrl_next;
         prdata_reg  <= prdata_next;
         pslverr_reg <= pslverr_next;
      end
   end

   // one driver for the whole struct rather than one per member
   assign stored = '{dma_dis:  ctrl_reg[DMA_DIS_BIT],
                     trig_dis: ctrl_reg[TRIG_DIS_BIT]};

   // one-cycle apply stage keeps modules from seeing half-written state
   disable_apply u_apply
   (
      .pclk      (pclk),
      .presetn   (presetn),
      .state_in  (stored),
      .state_out (applied)
   );

   // absent modules are held disabled regardless of the register
   always_comb
   begin
      dma_out_next  = {CHANNELS{applied.dma_dis | ~DMA_PRESENT}}; // RULE_01
      trig_out_next = applied.trig_dis | ~TRIG_PRESENT; // RULE_04
   end

   // one bit fans out to every channel, no per-channel control
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         dma_out_reg  <= '0; // RULE_08
         trig_out_reg <= 1'b0;
      end
      else
      begin
         dma_out_reg  <= dma_out_next; // RULE_03 RULE_02 RULE_07
         trig_out_reg <= trig_out_next;
      end
   end

   assign dma_channel_disable       = dma_out_reg;
   assign trigger_generator_disable = trig_out_reg;
   assign prdata  = prdata_reg;
   assign pslverr = pslverr_reg;
   // ready is registered: high only in the access cycle after each setup
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pready <= 1'b0;
      else
         pready <= setup;
   end

   // assertions
   sequence wr_dma_one;
      psel && !penable && pwrite && hit && pwdata[DMA_DIS_BIT];
   endsequence
   sequence wr_dma_zero;
      psel && !penable && pwrite && hit && !pwdata[DMA_DIS_BIT];
   endsequence

   property dma_set_p;
      @(posedge pclk) disable iff (!presetn)
         wr_dma_one |-> ##3 (&dma_channel_disable);
   endproperty
   dma_set_a: assert property (dma_set_p) // RULE_01
      else $error("dma not disabled three cycles after write of one");

   property dma_clr_p;
      @(posedge pclk) disable iff (!presetn)
         wr_dma_zero |-> ##3 (dma_channel_disable == '0 || !DMA_PRESENT);
   endproperty
   dma_clear_a: assert property (dma_clr_p) // RULE_02
      else $error("dma not enabled three cycles after write of zero");

   channels_together_a: assert property ( // RULE_03
      @(posedge pclk) disable iff (!presetn)
         (&dma_channel_disable) || (dma_channel_disable == '0))
      else $error("dma channels disagree");

   trig_follow_a: assert property ( // RULE_04
      @(posedge pclk) disable iff (!presetn)
         (psel && !penable && pwrite && hit) |->
            ##3 (trigger_generator_disable ==
                 ($past(pwdata[TRIG_DIS_BIT], 3) | !TRIG_PRESENT)))
      else $error("trigger disable does not follow bit 3");

   unimpl_zero_a: assert property ( // RULE_05
      @(posedge pclk) disable iff (!presetn)
         pready && !pslverr |-> (prdata & ~{16'h0000,
            DISABLE_CTRL7_MASK}) == 32'h0000_0000)
      else $error("unimplemented bits read non-zero");

   apply_delay_a: assert property ( // RULE_06
      @(posedge pclk) disable iff (!presetn)
         $changed(ctrl_reg[DMA_DIS_BIT]) |=>
            (applied.dma_dis == $past(ctrl_reg[DMA_DIS_BIT])))
      else $error("disable state not applied after one cycle");

   absent_off_a: assert property ( // RULE_07
      @(posedge pclk) disable iff (!presetn)
         !trigger_generator_disable |->
            TRIG_PRESENT && !$past(applied.trig_dis))
      else $error("trigger enabled while disabled or absent");

   reset_val_a: assert property ( // RULE_08
      @(posedge pclk) $rose(presetn) |-> ctrl_reg == 16'h0000)
      else $error("register not cleared by reset");
endmodule

// >>> sim/testbench.sv
// testbench: apb access and disable outputs of the module disable bank
`timescale 1ns/100ps
module testbench
   import module_disable_pkg::*;
;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [3:0]  dma;
   logic        trig;
   logic [31:0] rd;
   logic        er;
   logic [11:0] a;
   integer      err_total = 0;
   integer      cmp_count = 0;
   integer      model = 0;
   integer      d;

   module_disable_bank i_module_disable_bank
   (
      .pclk                      (pclk),
      .presetn                   (presetn),
      .psel                      (psel),
      .penable                   (penable),
      .pwrite                    (pwrite),
      .paddr                     (paddr),
      .pwdata                    (pwdata),
      .prdata                    (prdata),
      .pready                    (pready),
      .pslverr                   (pslverr),
      .dma_channel_disable       (dma),
      .trigger_generator_disable (trig)
   );

   // 40 MHz clock
   initial
   begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      cmp_count++;
      if (g !== e)
      begin
         err_total++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask

   // setup then access; the request is held until pready, no release here
   // so a following setup can come back to back
   task automatic apb(input logic w, input logic [11:0] ad,
                      input logic [31:0] wd);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= ad;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
   endtask

   task automatic idle();
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   // both module disables against the model register
   task automatic outs();
      chk("dma", model[4] ? 15 : 0, 32'(dma)); // all channels
      chk("trig", 32'(model[3]), 32'(trig));
   endtask

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // hang guard, far beyond the hundred or so cycles the tests need
   initial
   begin
      repeat (5000) @(posedge pclk);
      err_total++;
      end_of_test();
   end

   initial
   begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      presetn = 1'b0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      void'($urandom(1890));
      outs(); // enabled after reset
      apb(1'b0, 12'h000, 32'h0000_0000);
      chk("rdata", 0, rd);
      // random words, first four walk both bits; write and read back to back
      for (int i = 0; i < 12; i++)
      begin
         d = $urandom;
         if (i < 4)
            d[4:3] = i[1:0];
         a = 12'($urandom % 4);
         apb(1'b1, a, d);
         model = d & 32'h0000_0018;
         apb(1'b0, a, 32'h0000_0000);
         idle();
         chk("rdata", model, rd); // masked readback
         chk("slverr", 0, 32'(er));
         outs(); // applied after the delay
      end
      // unmapped word: refused, nothing stored
      a = {10'($urandom % 1023 + 1), 2'b00};
      apb(1'b1, a, 32'h0000_0018);
      chk("slverr", 1, 32'(er));
      apb(1'b0, a, 32'h0000_0000);
      chk("rdata", 0, rd);
      apb(1'b0, 12'h000, 32'h0000_0000);
      chk("rdata", model, rd); // register untouched
      // set both, then reset in mid-run
      apb(1'b1, 12'h000, 32'hFFFF_FFFF);
      model = 32'h0000_0018;
      idle();
      repeat (3) @(posedge pclk);
      outs(); // both disabled
      presetn <= 1'b0;
      model = 0;
      @(posedge pclk);
      outs(); // cleared by reset
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, 12'h000, 32'h0000_0000);
      idle();
      chk("rdata", 0, rd);
      end_of_test();
   end
endmodule
